// ===== pkg/pwe_regs.vh
`ifndef PWE_REGS_VH
`define PWE_REGS_VH

// ============================================================
// Register indices (byte address is four times the index)
`define PWE_IDX_STAT_ONE   8'hf3
`define PWE_IDX_STAT_TWO   8'hf4
`define PWE_IDX_EN_ONE     8'hf6
`define PWE_IDX_EN_TWO     8'hf7
`define PWE_IDX_ROUTE      8'hfe
`define PWE_IDX_GP_STAT    8'hff

// ============================================================
// Bus geometry
`define PWE_ADDR_W         10
`define PWE_IDX_LSB        2
`define PWE_IDX_MSB        9

// ============================================================
// Reset values and writable bit masks
`define PWE_RST_BYTE       8'h00
`define PWE_MASK_ONE       8'h7f
`define PWE_MASK_TWO       8'h3f
`define PWE_MASK_ROUTE     8'h77
`define PWE_MASK_GP        8'h07

// ============================================================
// First status and enable layout
`define PWE_B1_SER_C       6
`define PWE_B1_MOUSE       5
`define PWE_B1_KBD         4
`define PWE_B1_PRT         3
`define PWE_B1_FDC         2
`define PWE_B1_SER_A       1
`define PWE_B1_SER_B       0

// ============================================================
// Second status and enable layout
`define PWE_B2_SER_F       5
`define PWE_B2_SER_E       4
`define PWE_B2_HWMON       3
`define PWE_B2_WDT         2
`define PWE_B2_SER_D       1
`define PWE_B2_RING_B      0

// ============================================================
// Route register and general input status layout
`define PWE_RT_PSW_LSB     4
`define PWE_RT_PSW_MSB     6
`define PWE_RT_PME_LSB     0
`define PWE_RT_PME_MSB     2
`define PWE_GP_25          0
`define PWE_GP_26          1
`define PWE_GP_27          2

// ============================================================
// Event vector packing
`define PWE_EV_W           16
`define PWE_EV_ONE_LSB     0
`define PWE_EV_ONE_MSB     6
`define PWE_EV_TWO_LSB     7
`define PWE_EV_TWO_MSB     12
`define PWE_EV_GP_LSB      13
`define PWE_EV_GP_MSB      15

`endif

// ===== logic/pwe_wake_event_control.v
// Summary of operation
// [R1] Status bits sticky, write one clears
// [R2] Serial F event sets second status bit5
// [R3] Serial E event sets second status bit4
// [R4] Hardware monitor event sets second status bit3
// [R5] Watchdog timeout sets second status bit2
// [R6] Serial D event sets second status bit1
// [R7] Ring indicator B sets second status bit0
// [R8] Second enable bits 5,4 gate serial F,E
// [R9] Second enable bits 3,2 gate monitor, watchdog
// [R10] Second enable bits 1,0 gate serial D, ring
// [R11] First enable bits 6,5 gate serial C, mouse
// [R12] First enable bits 4,3 gate keyboard, printer
// [R13] First enable bits 2..0 gate floppy, serial A,B
// [R14] Route bits 6..4 pass inputs to power switch
// [R15] Route bits 2..0 pass inputs to PME
// [R16] First status: serial C bit6, mouse bit5
// [R17] First status: keyboard bit4, lower bits others
// [R18] PME active while any enabled flag set
// [R19] Flags set regardless of enable; zeros ignored
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "pwe_regs.vh"

module pwe_wake_event_control (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    // Event sources of the first group
    input  wire        serialPortCIrq,
    input  wire        mouseIrq,
    input  wire        keyboardControllerIrq,
    input  wire        printerPortIrq,
    input  wire        floppyControllerIrq,
    input  wire        serialPortAIrq,
    input  wire        serialPortBIrq,
    // Event sources of the second group
    input  wire        serialPortFIrq,
    input  wire        serialPortEIrq,
    input  wire        hardwareMonitorIrq,
    input  wire        watchdogTimeout,
    input  wire        serialPortDIrq,
    input  wire        ringIndicatorPortB,
    // General purpose input pins
    input  wire        generalInput25,
    input  wire        generalInput26,
    input  wire        generalInput27,
    // Wake outputs
    output wire        pmeEvent,
    output wire        powerSwitchOutput
);

    // ============================================================
    // Helpers

    // Sticky update: a new event wins over a clear in the same cycle
    function [7:0] stickyNext;
        input [7:0] cur;
        input [7:0] setBits;
        input [7:0] clrBits;
        input [7:0] mask;
        begin
            stickyNext = ((cur & ~clrBits) | setBits) & mask;
        end
    endfunction

    function regHit;
        input [7:0] idx;
        input [7:0] target;
        begin
            regHit = (idx == target);
        end
    endfunction

    // ============================================================
    // Declarations
    wire [`PWE_EV_W-1:0] evRaw;
    reg  [`PWE_EV_W-1:0] syncA_reg;
    reg  [`PWE_EV_W-1:0] syncB_reg;
    reg  [`PWE_EV_W-1:0] evPrev_reg;
    wire [`PWE_EV_W-1:0] evEdge;

    reg  [7:0]  statOne_reg;
    reg  [7:0]  statTwo_reg;
    reg  [7:0]  enOne_reg;
    reg  [7:0]  enTwo_reg;
    reg  [7:0]  route_reg;
    reg  [7:0]  gpStat_reg;
    reg  [7:0]  statOne_next;
    reg  [7:0]  statTwo_next;
    reg  [7:0]  gpStat_next;

    reg  [7:0]  setOne;
    reg  [7:0]  setTwo;
    reg  [7:0]  setGp;

    reg         pme_reg;
    reg         psw_reg;
    reg  [31:0] prdata_reg;

    wire [7:0]  regIdx;
    wire        hitStatOne;
    wire        hitStatTwo;
    wire        hitEnOne;
    wire        hitEnTwo;
    wire        hitRoute;
    wire        hitGp;
    wire        mapped;
    wire        wrAccess;
    wire [7:0]  wrByte;
    reg  [7:0]  rdByte;
    wire        pmeNext;
    wire        pswNext;

    // ============================================================
    // Event capture
    // Sources may run from other clocks, so every one is synchronised
    // and only a rising level counts as a new occurrence.
    assign evRaw = {generalInput27, generalInput26, generalInput25,
                    serialPortFIrq, serialPortEIrq, hardwareMonitorIrq,
                    watchdogTimeout, serialPortDIrq, ringIndicatorPortB,
                    serialPortCIrq, mouseIrq, keyboardControllerIrq,
                    printerPortIrq, floppyControllerIrq, serialPortAIrq,
                    serialPortBIrq};

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_reg  <= 16'h0000;
            syncB_reg  <= 16'h0000;
            evPrev_reg <= 16'h0000;
        end else begin
            syncA_reg  <= evRaw;
            syncB_reg  <= syncA_reg;
            evPrev_reg <= syncB_reg;
        end
    end

    assign evEdge = syncB_reg & ~evPrev_reg;

    // Enable bits never enter here, so flags latch even when disabled
    always @* begin
        setOne = `PWE_RST_BYTE;
        setTwo = `PWE_RST_BYTE;
        setGp  = `PWE_RST_BYTE;
        setOne[`PWE_EV_ONE_MSB:`PWE_EV_ONE_LSB] =
            evEdge[`PWE_EV_ONE_MSB:`PWE_EV_ONE_LSB]; // [R16] [R17] [R19]
        setTwo[`PWE_EV_TWO_MSB-`PWE_EV_TWO_LSB:0] =
            evEdge[`PWE_EV_TWO_MSB:`PWE_EV_TWO_LSB]; // [R2] [R3] [R4] [R5] [R6] [R7] [R19]
        setGp[`PWE_GP_27:`PWE_GP_25] =
            evEdge[`PWE_EV_GP_MSB:`PWE_EV_GP_LSB];
    end

    // ============================================================
    // APB decode
    // Zero wait states: every access completes in its first access cycle.
    assign regIdx     = paddr[`PWE_IDX_MSB:`PWE_IDX_LSB];
    assign hitStatOne = regHit(regIdx, `PWE_IDX_STAT_ONE);
    assign hitStatTwo = regHit(regIdx, `PWE_IDX_STAT_TWO);
    assign hitEnOne   = regHit(regIdx, `PWE_IDX_EN_ONE);
    assign hitEnTwo   = regHit(regIdx, `PWE_IDX_EN_TWO);
    assign hitRoute   = regHit(regIdx, `PWE_IDX_ROUTE);
    assign hitGp      = regHit(regIdx, `PWE_IDX_GP_STAT);
    assign mapped     = hitStatOne | hitStatTwo | hitEnOne | hitEnTwo
                        | hitRoute | hitGp;

    // Only the low byte lane holds register bits
    assign wrAccess = psel & penable & pwrite & pstrb[0] & mapped;
    assign wrByte   = pwdata[7:0];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_reg;

    always @* begin
        case (1'b1)
            hitStatOne: rdByte = statOne_reg;
            hitStatTwo: rdByte = statTwo_reg;
            hitEnOne:   rdByte = enOne_reg;
            hitEnTwo:   rdByte = enTwo_reg;
            hitRoute:   rdByte = route_reg;
            hitGp:      rdByte = gpStat_reg;
            default:    rdByte = `PWE_RST_BYTE;
        endcase
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_reg <= {24'h000000, rdByte};
        end
    end

    // ============================================================
    // Status registers
    always @* begin
        statOne_next = stickyNext(statOne_reg, setOne,
                                  (wrAccess & hitStatOne) ? wrByte : 8'h00,
                                  `PWE_MASK_ONE); // [R1] [R16] [R17] [R19]
        statTwo_next = stickyNext(statTwo_reg, setTwo,
                                  (wrAccess & hitStatTwo) ? wrByte : 8'h00,
                                  `PWE_MASK_TWO); // [R1] [R19]
        gpStat_next  = stickyNext(gpStat_reg, setGp,
                                  (wrAccess & hitGp) ? wrByte : 8'h00,
                                  `PWE_MASK_GP); // [R1]
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            statOne_reg <= `PWE_RST_BYTE;
            statTwo_reg <= `PWE_RST_BYTE;
            gpStat_reg  <= `PWE_RST_BYTE;
        end else begin
            statOne_reg <= statOne_next;
            statTwo_reg <= statTwo_next;
            gpStat_reg  <= gpStat_next;
        end
    end

    // ============================================================
    // Enable and route registers
    // Reserved bits are masked off on write and so read back as zero.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enOne_reg <= `PWE_RST_BYTE;
            enTwo_reg <= `PWE_RST_BYTE;
            route_reg <= `PWE_RST_BYTE;
        end else begin
            if (wrAccess & hitEnOne) begin
                enOne_reg <= wrByte & `PWE_MASK_ONE; // [R11] [R12] [R13]
            end
            if (wrAccess & hitEnTwo) begin
                enTwo_reg <= wrByte & `PWE_MASK_TWO; // [R8] [R9] [R10]
            end
            if (wrAccess & hitRoute) begin
                route_reg <= wrByte & `PWE_MASK_ROUTE; // [R14] [R15]
            end
        end
    end

    // ============================================================
    // Wake outputs
    // Outputs follow the flags, so clearing the last enabled flag
    // releases the event one cycle later.
    assign pmeNext = (|(statOne_reg & enOne_reg))     // [R11] [R12] [R13] [R18]
                   | (|(statTwo_reg & enTwo_reg))     // [R8] [R9] [R10] [R18]
                   | (|(gpStat_reg[`PWE_GP_27:`PWE_GP_25]
                        & route_reg[`PWE_RT_PME_MSB:`PWE_RT_PME_LSB])); // [R15]
    assign pswNext = |(gpStat_reg[`PWE_GP_27:`PWE_GP_25]
                       & route_reg[`PWE_RT_PSW_MSB:`PWE_RT_PSW_LSB]); // [R14]

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pme_reg <= 1'b0;
            psw_reg <= 1'b0;
        end else begin
            pme_reg <= pmeNext; // [R18]
            psw_reg <= pswNext;
        end
    end

    assign pmeEvent          = pme_reg;
    assign powerSwitchOutput = psw_reg;

endmodule

// ===== test/pwe_host_model.sv
`timescale 1ns/1ps
module pwe_host_model (
    // Clock and reset
    input logic       ref_clk,
    input logic       sys_rst,
    // Wake lines from the device
    input logic       pmeEvent,
    input logic       powerSwitchOutput,
    // Wake requests seen
    output logic [7:0] pmeWakes,
    output logic [7:0] pswWakes
);
    logic pmeSeen_reg;
    logic pswSeen_reg;
    // A level held high is one request, so only rising edges count
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pmeSeen_reg <= 1'b0;
            pswSeen_reg <= 1'b0;
            pmeWakes    <= 8'h00;
            pswWakes    <= 8'h00;
        end else begin
            pmeSeen_reg <= pmeEvent;
            pswSeen_reg <= powerSwitchOutput;
            if (pmeEvent && !pmeSeen_reg) pmeWakes <= pmeWakes + 8'h01;
            if (powerSwitchOutput && !pswSeen_reg) pswWakes <= pswWakes + 8'h01;
        end
    end
endmodule

// ===== test/pwe_wake_sva.sv
`timescale 1ns/1ps
`include "pwe_regs.vh"
module pwe_wake_sva (
    // Clock and reset
    input logic        ref_clk,
    input logic        sys_rst,
    // Register bus
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [9:0]  paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic        pready,
    input logic        pslverr,
    input logic [31:0] prdata,
    // Watched events and outputs
    input logic        serialPortFIrq,
    input logic        generalInput27,
    input logic        pmeEvent,
    input logic        powerSwitchOutput
);
    // ============================================================
    // Shadow of the enable and route registers
    wire [7:0] idx = paddr[9:2];
    wire mapped = idx == `PWE_IDX_STAT_ONE || idx == `PWE_IDX_STAT_TWO || idx == `PWE_IDX_EN_ONE
        || idx == `PWE_IDX_EN_TWO || idx == `PWE_IDX_ROUTE || idx == `PWE_IDX_GP_STAT;
    wire wrTaken = psel && penable && pwrite && pstrb[0];
    logic [7:0] enOne_reg;
    logic [7:0] enTwo_reg;
    logic [7:0] route_reg;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enOne_reg <= 8'h00;
            enTwo_reg <= 8'h00;
            route_reg <= 8'h00;
        end else if (wrTaken) begin
            if (idx == `PWE_IDX_EN_ONE) enOne_reg <= pwdata[7:0] & `PWE_MASK_ONE;
            if (idx == `PWE_IDX_EN_TWO) enTwo_reg <= pwdata[7:0] & `PWE_MASK_TWO;
            if (idx == `PWE_IDX_ROUTE) route_reg <= pwdata[7:0] & `PWE_MASK_ROUTE;
        end
    end
    // ============================================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Enable held and no clear issued while the flag travels
    sequence holdEn(e);
        (e && !(psel && pwrite)) [*4];
    endsequence
    ready_always_a: assert property (pready) else $error("pready low");
    slverr_map_a: assert property (pslverr == (psel && penable && !mapped)) else $error("slverr");
    upper_zero_a: assert property (prdata[31:8] == 24'h000000) else $error("upper bits");
    unmapped_zero_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read data");
    write_keeps_a: assert property (psel && penable && pwrite |=> $stable(prdata))
        else $error("prdata moved on write");
    enable_read_a: assert property (psel && penable && !pwrite && idx == `PWE_IDX_EN_ONE |->
        prdata[7:0] == enOne_reg) else $error("enable readback");
    route_read_a: assert property (psel && penable && !pwrite && idx == `PWE_IDX_ROUTE |->
        prdata[7:0] == route_reg) else $error("route readback");
    pme_quiet_a: assert property ((enOne_reg == 8'h00 && enTwo_reg == 8'h00
        && route_reg[2:0] == 3'h0) [*2] |-> !pmeEvent) else $error("pme w/o enable");
    psw_quiet_a: assert property ((route_reg[6:4] == 3'h0) [*2] |-> !powerSwitchOutput)
        else $error("psw w/o route");
    serf_wake_a: assert property ($rose(serialPortFIrq) ##1 holdEn(enTwo_reg[5]) |->
        ##[0:1] pmeEvent) else $error("serial F wake late");
    gp_switch_a: assert property ($rose(generalInput27) ##1 holdEn(route_reg[6]) |->
        ##[0:1] powerSwitchOutput) else $error("general_input_27 switch late");
endmodule

bind pwe_wake_event_control pwe_wake_sva chk_u (.ref_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .serialPortFIrq, .generalInput27,
    .pmeEvent, .powerSwitchOutput);

// ===== test/pwe_wake_event_control_tb.sv
`timescale 1ns/1ps
`include "pwe_regs.vh"
module pwe_wake_event_control_tb;
    logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h1;
    logic [15:0] ev = 16'h0000;
    logic [15:0] rowTab [0:12];
    logic [15:0] regTab [0:2];
    logic [7:0] pmeWakes, pswWakes, stIdx, m, enIdx;
    logic pready, pslverr, err, pmeEvent, powerSwitchOutput;
    int errors = 0, checks_done = 0;
    // ============================================================
    // Device and host
    pwe_wake_event_control dut_u (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .pslverr, .prdata, .serialPortBIrq(ev[0]),
        .serialPortAIrq(ev[1]), .floppyControllerIrq(ev[2]), .printerPortIrq(ev[3]),
        .keyboardControllerIrq(ev[4]), .mouseIrq(ev[5]), .serialPortCIrq(ev[6]),
        .ringIndicatorPortB(ev[7]), .serialPortDIrq(ev[8]), .watchdogTimeout(ev[9]),
        .hardwareMonitorIrq(ev[10]), .serialPortEIrq(ev[11]), .serialPortFIrq(ev[12]),
        .generalInput25(ev[13]), .generalInput26(ev[14]), .generalInput27(ev[15]),
        .pmeEvent, .powerSwitchOutput);
    pwe_host_model host_u (.ref_clk, .sys_rst, .pmeEvent, .powerSwitchOutput, .pmeWakes,
        .pswWakes);
    initial forever #2.5 ref_clk = ~ref_clk;
    // ============================================================
    // Tasks
    task end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            end_sim;
        end
    endtask
    // Event held two cycles, then time for sync, flag and output
    task pulse(input int k);
        @(posedge ref_clk);
        ev[k] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        ev[k] <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    // ============================================================
    // Sequence
    initial begin
        for (int i = 0; i < 13; i++)
            rowTab[i] = (i < 7) ? {`PWE_IDX_STAT_ONE, 8'h01 << i}
                                : {`PWE_IDX_STAT_TWO, 8'h01 << (i - 7)};
        regTab = '{{`PWE_IDX_EN_ONE, `PWE_MASK_ONE}, {`PWE_IDX_EN_TWO, `PWE_MASK_TWO},
                   {`PWE_IDX_ROUTE, `PWE_MASK_ROUTE}};
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int r = 0; r < 13; r++) begin
            {stIdx, m} = rowTab[r];
            enIdx = (stIdx == `PWE_IDX_STAT_ONE) ? `PWE_IDX_EN_ONE : `PWE_IDX_EN_TWO;
            apb(1'b1, enIdx, m);
            pulse(r);
            apb(1'b0, stIdx, 8'h00);
            chk(rd, {24'h0, m});
            @(negedge ref_clk);
            chk(pmeEvent, 1'b1);
            apb(1'b1, stIdx, m);
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            chk(pmeEvent, 1'b0);
        end
        // Masked flag still latches and survives a zero write
        apb(1'b1, `PWE_IDX_EN_TWO, 8'h00);
        pulse(9);
        apb(1'b1, `PWE_IDX_STAT_TWO, 8'h00);
        apb(1'b0, `PWE_IDX_STAT_TWO, 8'h00);
        chk(rd, 32'h4);
        chk(pmeEvent, 1'b0);
        apb(1'b1, `PWE_IDX_STAT_TWO, 8'h04);
        apb(1'b0, `PWE_IDX_STAT_TWO, 8'h00);
        chk(rd, 32'h0);
        // Routed general inputs
        apb(1'b1, `PWE_IDX_ROUTE, 8'h40);
        pulse(15);
        @(negedge ref_clk);
        chk({powerSwitchOutput, pmeEvent}, 2'b10);
        apb(1'b1, `PWE_IDX_GP_STAT, 8'h04);
        apb(1'b1, `PWE_IDX_ROUTE, 8'h01);
        pulse(13);
        @(negedge ref_clk);
        chk({powerSwitchOutput, pmeEvent}, 2'b01);
        apb(1'b0, 8'h10, 8'h00);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        chk({pswWakes, pmeWakes}, {8'd1, 8'd14});
        // A write without the low byte strobe must leave the enable alone
        pstrb <= 4'h0;
        apb(1'b1, `PWE_IDX_EN_ONE, 8'h00);
        pstrb <= 4'h1;
        apb(1'b0, `PWE_IDX_EN_ONE, 8'h00);
        chk(rd, 32'h40);
        // Reserved bits, then a mid-run reset clears everything
        foreach (regTab[i]) begin
            apb(1'b1, regTab[i][15:8], 8'hff);
            apb(1'b0, regTab[i][15:8], 8'h00);
            chk(rd, {24'h0, regTab[i][7:0]});
        end
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (regTab[i]) begin
            apb(1'b0, regTab[i][15:8], 8'h00);
            chk(rd, 32'h0);
        end
        apb(1'b0, `PWE_IDX_GP_STAT, 8'h00);
        chk(rd, 32'h0);
        chk(pmeEvent, 1'b0);
        end_sim;
    end
endmodule
